/* File: inc/gop_defs.vh */
`ifndef GOP_DEFS_VH
`define GOP_DEFS_VH

// ----------------------------------------------------------------
// Register offsets (byte registers on the plain port)
// ----------------------------------------------------------------
`define GOP_A_DATA0      4'h0
`define GOP_A_DATA1      4'h1
`define GOP_A_DATA2      4'h2
`define GOP_A_DATA3      4'h3
`define GOP_A_DATA5      4'h4
`define GOP_A_FLOAT0     4'h5
`define GOP_A_FLOAT1     4'h6
`define GOP_A_FLOAT2     4'h7
`define GOP_A_SPECIAL    4'h8
`define GOP_A_MODE       4'h9
`define GOP_A_LEVEL0     4'ha
`define GOP_A_LEVEL1     4'hb
`define GOP_A_LEVEL2     4'hc
`define GOP_A_LEVEL3     4'hd
`define GOP_A_LEVEL5     4'he

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GOP_RST_DATA     8'h00
`define GOP_RST_FLOAT    8'h00
`define GOP_RST_SPECIAL  5'h00
`define GOP_RST_MODE     2'h0

// ----------------------------------------------------------------
// Field positions in the first float register
// ----------------------------------------------------------------
`define GOP_F_GROUP0_LOW   0
`define GOP_F_GROUP0_HIGH  1
`define GOP_F_GROUP1_LOW   2
`define GOP_F_GROUP1_HIGH  3
`define GOP_F_SPARE_A      4
`define GOP_F_SPARE_B      5
`define GOP_F_PIN_FIFTY    6
`define GOP_F_PIN_FIFTYONE 7

// ----------------------------------------------------------------
// Bus modes
// ----------------------------------------------------------------
`define GOP_MODE_SINGLE  2'h0
`define GOP_MODE_EXP64K  2'h1
`define GOP_MODE_EXP512K 2'h2

// ----------------------------------------------------------------
// Pin indices in the flat pin vector
// ----------------------------------------------------------------
`define GOP_P_RD         19
`define GOP_P_WR         20
`define GOP_P_CL         21
`define GOP_P_FR         22
`define GOP_P_TOUT       23
`define GOP_P_CE0        24
`define GOP_P_FOUT       28
`define GOP_P_BZ         32
`define GOP_P_BACK       33

`endif

/* File: rtl/gop_port_bank.v */
// Notes on behaviour
// - The full variant has 34 output pins and the reduced one has 30.
// - Port logic owns the pins only in single-chip mode; expanded modes give some pins to the bus.
// - Data and float bits of pins given to the bus stay plain storage with no effect on them.
// - Data and float bits of the four unbonded pins stay read/write storage.
// - Every pin is an output that software can float; pins above the first sixteen are always push-pull.
// - Five pins can carry a special signal instead of their data level.
// - Each of the first sixteen pins is fixed as push-pull or open-drain, push-pull by default.
// - The first sixteen pins float in nibble groups; every other pin floats alone.
// - A float bit of 1 floats its pin or group, 0 drives it in its fixed push-pull or open-drain style.
// - A reserved 2-bit field in float space is plain read/write storage.
// - A data bit of 1 drives its pin high (releases it on an open-drain pin) and 0 drives it low when not floated.
// - Data writes land while floated and show as soon as the pin drives again.
// - On the reduced variant the float bits of absent pins are plain storage.
//
// Added by the designer: the plain strobed port and the register offsets.
`include "gop_defs.vh"

module gop_port_bank #(
   parameter        FULL_VARIANT = 1,
   parameter [15:0] OD_MASK      = 16'h0000
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        ce_i,
   input  wire [3:0]  addr_i,
   input  wire [7:0]  wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   input  wire [18:0] bus_addr_i,
   input  wire        bus_rd_n_i,
   input  wire        bus_wr_n_i,
   input  wire [3:0]  bus_ce_n_i,
   input  wire        bus_back_n_i,
   input  wire [4:0]  spec_sig_i,
   output wire [7:0]  rdata_o,
   output wire [33:0] pin_o,
   output wire [33:0] pin_oe_o
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   reg  [7:0]  data0_reg;
   reg  [7:0]  data1_reg;
   reg  [7:0]  data2_reg;
   reg  [7:0]  data3_reg;
   reg  [1:0]  data5_reg;
   reg  [7:0]  float0_reg;
   reg  [7:0]  float1_reg;
   reg  [7:0]  float2_reg;
   reg  [4:0]  special_reg;
   reg  [1:0]  mode_reg;
   reg  [7:0]  rdata_reg;
   reg  [33:0] pin_reg;
   reg  [33:0] pin_oe_reg;

   reg  [7:0]  rdata_next;
   reg  [33:0] pin_next;
   reg  [33:0] pin_oe_next;

   wire [33:0] data_vec;
   wire [33:0] float_vec;
   wire [33:0] od_vec;
   wire        wr_en;
   wire        rd_en;

   assign wr_en = ce_i & wr_i;
   assign rd_en = ce_i & rd_i;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Spreads the four nibble group bits over the first sixteen pins
   function [15:0] group_spread;
      input [3:0] grp;
      integer     k;
      begin
         group_spread = 16'h0000;
         for (k = 0; k < 16; k = k + 1) begin
            group_spread[k] = grp[k / 4];
         end
      end
   endfunction

   // Register readback; also used for the pin level view
   function [7:0] read_mux;
      input [3:0]  a;
      input [33:0] lvl;
      begin
         case (a)
            `GOP_A_DATA0:   read_mux = data0_reg;
            `GOP_A_DATA1:   read_mux = data1_reg;
            `GOP_A_DATA2:   read_mux = data2_reg;
            `GOP_A_DATA3:   read_mux = data3_reg;
            `GOP_A_DATA5:   read_mux = {6'h00, data5_reg};
            `GOP_A_FLOAT0:  read_mux = float0_reg;
            `GOP_A_FLOAT1:  read_mux = float1_reg;
            `GOP_A_FLOAT2:  read_mux = float2_reg;
            `GOP_A_SPECIAL: read_mux = {3'h0, special_reg};
            `GOP_A_MODE:    read_mux = {6'h00, mode_reg};
            `GOP_A_LEVEL0:  read_mux = lvl[7:0];
            `GOP_A_LEVEL1:  read_mux = lvl[15:8];
            `GOP_A_LEVEL2:  read_mux = lvl[23:16];
            `GOP_A_LEVEL3:  read_mux = lvl[31:24];
            `GOP_A_LEVEL5:  read_mux = {6'h00, lvl[33:32]};
            default:        read_mux = 8'h00;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   // Writes are taken in any bus mode and while floated, so bus-owned
   // and unbonded pins keep working storage.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data0_reg   <= `GOP_RST_DATA;
         data1_reg   <= `GOP_RST_DATA;
         data2_reg   <= `GOP_RST_DATA;
         data3_reg   <= `GOP_RST_DATA;
         data5_reg   <= 2'h0;
         float0_reg  <= `GOP_RST_FLOAT;
         float1_reg  <= `GOP_RST_FLOAT;
         float2_reg  <= `GOP_RST_FLOAT;
         special_reg <= `GOP_RST_SPECIAL;
         mode_reg    <= `GOP_RST_MODE;
      end else if (wr_en) begin
         case (addr_i)
            `GOP_A_DATA0:   data0_reg   <= wdata_i;
            `GOP_A_DATA1:   data1_reg   <= wdata_i;
            `GOP_A_DATA2:   data2_reg   <= wdata_i;
            `GOP_A_DATA3:   data3_reg   <= wdata_i;
            `GOP_A_DATA5:   data5_reg   <= wdata_i[1:0];
            `GOP_A_FLOAT0:  float0_reg  <= wdata_i;
            `GOP_A_FLOAT1:  float1_reg  <= wdata_i;
            `GOP_A_FLOAT2:  float2_reg  <= wdata_i;
            `GOP_A_SPECIAL: special_reg <= wdata_i[4:0];
            `GOP_A_MODE:    mode_reg    <= wdata_i[1:0];
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Flat views of data, float and drive style
   // ----------------------------------------------------------------
   assign data_vec = {data5_reg, data3_reg, data2_reg,
                      data1_reg, data0_reg};

   // Spare bits 4 and 5 of the first float register map to no pin
   assign float_vec = {float0_reg[`GOP_F_PIN_FIFTYONE],
                       float0_reg[`GOP_F_PIN_FIFTY],
                       float2_reg,
                       float1_reg,
                       group_spread(float0_reg[3:0])};

   // Open-drain exists only on the first sixteen pins
   assign od_vec = {18'h00000, OD_MASK};

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   always @* begin
      // Plain port behaviour: level from data, float from control
      pin_next    = data_vec;
      pin_oe_next = ~float_vec & ~(od_vec & data_vec);

      // Special signals replace the level, float control still applies
      if (special_reg[0]) begin
         pin_next[`GOP_P_CL] = spec_sig_i[0];
      end
      if (special_reg[1]) begin
         pin_next[`GOP_P_FR] = spec_sig_i[1];
      end
      if (special_reg[2]) begin
         pin_next[`GOP_P_TOUT] = spec_sig_i[2];
      end
      if (special_reg[3]) begin
         pin_next[`GOP_P_FOUT] = spec_sig_i[3];
      end
      if (special_reg[4]) begin
         pin_next[`GOP_P_BZ] = spec_sig_i[4];
      end

      // Bus-owned pins are always driven and ignore their registers
      case (mode_reg)
         `GOP_MODE_SINGLE: begin
         end
         `GOP_MODE_EXP64K: begin
            pin_next[15:0]          = bus_addr_i[15:0];
            pin_oe_next[15:0]       = 16'hffff;
            pin_next[`GOP_P_RD]     = bus_rd_n_i;
            pin_next[`GOP_P_WR]     = bus_wr_n_i;
            pin_oe_next[`GOP_P_RD]  = 1'b1;
            pin_oe_next[`GOP_P_WR]  = 1'b1;
         end
         default: begin
            pin_next[18:0]          = bus_addr_i;
            pin_oe_next[18:0]       = 19'h7ffff;
            pin_next[`GOP_P_RD]     = bus_rd_n_i;
            pin_next[`GOP_P_WR]     = bus_wr_n_i;
            pin_oe_next[`GOP_P_RD]  = 1'b1;
            pin_oe_next[`GOP_P_WR]  = 1'b1;
            pin_next[27:24]         = bus_ce_n_i;
            pin_oe_next[27:24]      = 4'hf;
            pin_next[`GOP_P_BACK]   = bus_back_n_i;
            pin_oe_next[`GOP_P_BACK] = 1'b1;
         end
      endcase

      // Reduced variant: four pins do not exist, their bits stay storage
      if (FULL_VARIANT == 0) begin
         pin_next[31:29]          = 3'h0;
         pin_oe_next[31:29]       = 3'h0;
         pin_next[`GOP_P_BACK]    = 1'b0;
         pin_oe_next[`GOP_P_BACK] = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Output and readback flip-flops
   // ----------------------------------------------------------------
   // Pins come from flip-flops so a glitch on the special or bus inputs
   // never reaches the pad mid-cycle; cost is one cycle of latency.
   always @* begin
      rdata_next = 8'h00;
      if (rd_en) begin
         rdata_next = read_mux(addr_i, pin_reg);
      end
   end

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_reg  <= 8'h00;
         pin_reg    <= 34'h000000000;
         pin_oe_reg <= 34'h000000000;
      end else if (ce_i) begin
         rdata_reg  <= rdata_next;
         pin_reg    <= pin_next;
         pin_oe_reg <= pin_oe_next;
      end
   end

   assign rdata_o  = rdata_reg;
   assign pin_o    = pin_reg;
   assign pin_oe_o = pin_oe_reg;

endmodule

/* File: sim/gop_port_bank_monitor.sv */
module gop_port_bank_monitor #(
   parameter FULL_VARIANT = 1
) (
   input logic        clk_i,
   input logic        rst_n_i,
   input logic        ce_i,
   input logic [3:0]  addr_i,
   input logic [7:0]  wdata_i,
   input logic        wr_i,
   input logic        rd_i,
   input logic [18:0] bus_addr_i,
   input logic        bus_rd_n_i,
   input logic        bus_wr_n_i,
   input logic [3:0]  bus_ce_n_i,
   input logic        bus_back_n_i,
   input logic [4:0]  spec_sig_i,
   input logic [7:0]  rdata_o,
   input logic [33:0] pin_o,
   input logic [33:0] pin_oe_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ------------
   // Shadow state
   // ------------
   logic [7:0] data0_reg;
   logic [7:0] flt0_reg;
   logic [1:0] mode_reg;
   logic       single_reg;
   wire        wr_ok = ce_i && wr_i;
   // Pins lag the registers by one edge, so single_reg lags too
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data0_reg <= 8'h00;
         flt0_reg <= 8'h00;
         mode_reg <= 2'h0;
         single_reg <= 1'b0;
      end else begin
         if (wr_ok && addr_i == 4'h0) data0_reg <= wdata_i;
         if (wr_ok && addr_i == 4'h5) flt0_reg <= wdata_i;
         if (wr_ok && addr_i == 4'h9) mode_reg <= wdata_i[1:0];
         single_reg <= ce_i && mode_reg == 2'h0;
      end
   end
   // ----------
   // Properties
   // ----------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_rd(logic [3:0] a);
      ce_i && rd_i && addr_i == a;
   endsequence
   property p_rd_data;
      s_rd(4'h0) |=> rdata_o == $past(data0_reg);
   endproperty
   a_rd_data: assert property (p_rd_data)
      else $error("data byte read back wrong");
   property p_rd_spare;
      s_rd(4'h5) |=> rdata_o == $past(flt0_reg);
   endproperty
   a_rd_spare: assert property (p_rd_spare)
      else $error("float byte read back wrong");
   property p_rd_idle;
      ce_i && !rd_i |=> rdata_o == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside its cycle");
   property p_grp_oe;
      pin_oe_o[3:0] inside {4'h0, 4'hf} && pin_oe_o[15:12] inside {4'h0, 4'hf};
   endproperty
   a_grp_oe: assert property (p_grp_oe)
      else $error("nibble group split");
   property p_float_oe;
      single_reg |-> pin_oe_o[3:0] == {4{~$past(flt0_reg[0])}};
   endproperty
   a_float_oe: assert property (p_float_oe)
      else $error("group float wrong");
   property p_dc;
      single_reg |-> ((pin_o[7:0] ^ $past(data0_reg)) & pin_oe_o[7:0]) == 8'h00;
   endproperty
   a_dc: assert property (p_dc)
      else $error("pin level differs from data");
   property p_exp64;
      $past(mode_reg) != 2'h0 |-> pin_o[15:0] == $past(bus_addr_i[15:0])
         && pin_oe_o[20:19] == 2'h3
         && pin_o[20:19] == {$past(bus_wr_n_i), $past(bus_rd_n_i)};
   endproperty
   a_exp64: assert property (p_exp64)
      else $error("bus pins wrong in expanded mode");
   property p_exp512;
      $past(mode_reg[1]) |-> pin_o[18:16] == $past(bus_addr_i[18:16])
         && pin_o[27:24] == $past(bus_ce_n_i)
         && (FULL_VARIANT == 0 || pin_o[33] == $past(bus_back_n_i));
   endproperty
   a_exp512: assert property (p_exp512)
      else $error("wide bus pins wrong");
   property p_reduced;
      FULL_VARIANT == 0 |-> pin_oe_o[31:29] == 3'h0 && !pin_oe_o[33];
   endproperty
   a_reduced: assert property (p_reduced)
      else $error("absent pin driven");
endmodule

bind gop_port_bank gop_port_bank_monitor #(
   .FULL_VARIANT(FULL_VARIANT)
) gop_port_bank_monitor_i (
   .clk_i, .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .bus_addr_i,
   .bus_rd_n_i, .bus_wr_n_i, .bus_ce_n_i, .bus_back_n_i, .spec_sig_i,
   .rdata_o, .pin_o, .pin_oe_o
);

/* File: sim/tb_general_output_port_bank.sv */
`include "gop_defs.vh"
module tb_general_output_port_bank;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        ce = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [18:0] baddr = 19'h5a5a5;
   logic [4:0]  spec = 5'h00;
   logic        brd = 1'b0;
   logic        bwr = 1'b1;
   logic [3:0]  bce = 4'ha;
   logic        bback = 1'b0;
   logic [7:0]  rdata;
   logic [33:0] pin;
   logic [33:0] oe;
   logic [33:0] oe2;
   int          num_errors = 0;
   int          num_checks = 0;
   // Each row: address, write data, expected read back
   logic [19:0] rows [12] = '{
      {`GOP_A_DATA0, 16'ha5a5}, {`GOP_A_DATA1, 16'h5a5a},
      {`GOP_A_DATA2, 16'hc3c3}, {`GOP_A_DATA3, 16'h3c3c},
      {`GOP_A_DATA5, 16'hff03}, {`GOP_A_FLOAT0, 16'h3030},
      {`GOP_A_FLOAT1, 16'h0f0f}, {`GOP_A_FLOAT2, 16'hf0f0},
      {`GOP_A_SPECIAL, 16'he000}, {`GOP_A_MODE, 16'hfc00},
      {`GOP_A_LEVEL0, 16'h00a5}, {4'hf, 16'hff00}};
   always #12.5 clk = ~clk;
   // Default drive style kept: every pin push-pull, none open-drain
   gop_port_bank gop_port_bank_i (
      .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .bus_addr_i(baddr), .bus_rd_n_i(brd),
      .bus_wr_n_i(bwr), .bus_ce_n_i(bce), .bus_back_n_i(bback),
      .spec_sig_i(spec), .rdata_o(rdata), .pin_o(pin), .pin_oe_o(oe));
   // Reduced variant shares every input; only its enables are compared
   gop_port_bank #(.FULL_VARIANT(0)) gop_port_bank_r_i (
      .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .bus_addr_i(baddr), .bus_rd_n_i(brd),
      .bus_wr_n_i(bwr), .bus_ce_n_i(bce), .bus_back_n_i(bback),
      .spec_sig_i(spec), .rdata_o(), .pin_o(), .pin_oe_o(oe2));
   // -----
   // Tasks
   // -----
   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk({26'h0, rdata}, {26'h0, e});
   endtask
   task automatic settle();
      @(posedge clk);
      #1;
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      #20000;
      num_errors++;
      end_sim();
   end
   // -------------
   // Main sequence
   // -------------
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      chk(oe, 34'h3_ffff_ffff);
      chk(pin, 34'h0);
      chk(oe2, 34'h1_1fff_ffff);
      foreach (rows[i]) begin
         wr_reg(rows[i][19:16], rows[i][15:8]);
         rd_reg(rows[i][19:16], rows[i][7:0]);
      end
      chk(oe, 34'h3_0ff0_ffff);
      chk(oe2, 34'h1_0ff0_ffff);
      chk(pin & 34'h3_0ff0_ffff, 34'h3_0cc0_5aa5);
      wr_reg(`GOP_A_FLOAT0, 8'h01);
      wr_reg(`GOP_A_DATA0, 8'h0f);
      settle();
      chk({30'h0, oe[3:0]}, 34'h0);
      wr_reg(`GOP_A_FLOAT0, 8'h00);
      settle();
      chk({30'h0, pin[3:0] & oe[3:0]}, 34'hf);
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(`GOP_A_DATA0, 8'h11);
      ce <= 1'b1;
      rd_reg(`GOP_A_DATA0, 8'h0f);
      wr_reg(`GOP_A_MODE, {6'h0, `GOP_MODE_EXP64K});
      wr_reg(`GOP_A_DATA0, 8'h77);
      rd_reg(`GOP_A_DATA0, 8'h77);
      chk({18'h0, pin[15:0]}, 34'h0a5a5);
      chk({32'h0, pin[20:19] & oe[20:19]}, 34'h2);
      @(posedge clk);
      baddr <= 19'h31234;
      wr_reg(`GOP_A_MODE, {6'h0, `GOP_MODE_EXP512K});
      settle();
      chk({15'h0, pin[18:0]}, 34'h31234);
      chk({29'h0, pin[33], pin[27:24]}, 34'h0a);
      @(posedge clk);
      brd <= 1'b1;
      bwr <= 1'b0;
      bce <= 4'h5;
      bback <= 1'b1;
      settle();
      chk({27'h0, pin[33], pin[27:24], pin[20:19]}, 34'h55);
      wr_reg(`GOP_A_MODE, 8'h00);
      wr_reg(`GOP_A_FLOAT2, 8'h00);
      wr_reg(`GOP_A_SPECIAL, 8'h1f);
      @(posedge clk);
      spec <= 5'h15;
      settle();
      chk({29'h0, pin[32], pin[28], pin[23:21]}, 34'h15);
      spec <= 5'h0a;
      settle();
      chk({29'h0, pin[32], pin[28], pin[23:21]}, 34'h0a);
      end_sim();
   end
endmodule
